//--- include/uab_regs.svh
`ifndef UAB_REGS_SVH
`define UAB_REGS_SVH

// ============================================================
// register offsets
`define UAB_ADDR_CTRL       8'h00
`define UAB_ADDR_DIV_LOW    8'h01
`define UAB_ADDR_DIV_HIGH   8'h02
`define UAB_ADDR_RX_DATA    8'h03

// ============================================================
// control register fields
`define UAB_BIT_AB_EN       0
`define UAB_BIT_WAKE_EN     1
`define UAB_BIT_WIDE        2
`define UAB_BIT_HSPEED      3
`define UAB_BIT_AB_OVF      4
`define UAB_BIT_IDLE        5
`define UAB_BIT_INT         6

// ============================================================
// reset values
`define UAB_RST_DIV         8'h00
`define UAB_RST_DATA        8'h00

// ============================================================
// prescaler masks: base clock and autobaud clock per speed setting
`define UAB_BASE_MASK_SLOW  9'h03F
`define UAB_BASE_MASK_MID   9'h00F
`define UAB_BASE_MASK_FAST  9'h003
`define UAB_ABD_MASK_SLOW   9'h1FF
`define UAB_ABD_MASK_MID    9'h07F
`define UAB_ABD_MASK_FAST   9'h01F

// ============================================================
// timing counts
`define UAB_ABD_RISES       3'h5
`define UAB_DATA_BITS       4'h8

`endif

//--- include/uab_pkg.sv
package uab_pkg;

    // ============================================================
    // autobaud sequence states
    typedef enum logic [2:0] {
        UAB_AB_OFF   = 3'b000,
        UAB_AB_BREAK = 3'b001,
        UAB_AB_START = 3'b010,
        UAB_AB_FIRST = 3'b011,
        UAB_AB_COUNT = 3'b100
    } uab_ab_state_t;

    // ============================================================
    // receiver states
    typedef enum logic [1:0] {
        UAB_RX_IDLE  = 2'b00,
        UAB_RX_START = 2'b01,
        UAB_RX_DATA  = 2'b10,
        UAB_RX_STOP  = 2'b11
    } uab_rx_state_t;

endpackage

//--- logic/uab_autobaud_wake.sv
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "uab_regs.svh"
// What this block does
// RQ1: autobaud enable starts calibration, receiver held idle
// RQ2: calibration times the 55h sync byte
// RQ3: counting begins at first rise after start
// RQ4: fifth rise: keep count, clear enable, interrupt
// RQ5: software reads data register; read clears flag
// RQ6: both divisor registers form one 16-bit counter
// RQ7: counter clocked at one eighth base clock
// RQ8: speed bits select base and autobaud clocks
// RQ9: counter starts at one; software subtracts one
// RQ10: software checks high byte zero for overflow
// RQ11: with wake enable, calibrate byte after break
// RQ12: counter overflow sets overflow flag and interrupt
// RQ13: counting continues; idle flag rises on fifth
// RQ14: read after overflow: fifth rise re-raises interrupt
// RQ15: early enable clear: later falls become starts
// RQ16: software clears overflow after idle seen
// RQ17: in sleep receiver clocks and generator stop
// RQ18: wake enable disables reception, watches line
// RQ19: line falling edge raises interrupt; read clears
// RQ20: wake interrupt raised in sleep and awake
// RQ21: wake enable clears itself on break end
// RQ22: non-zero character: first low is wake event
// RQ23: sender wake character all zeros, ten bits
// RQ24: software checks idle before setting wake enable
// RQ25: overflow flag held until software clears it

module uab_autobaud_wake
    import uab_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    input  wire logic       sleep_i,
    input  wire logic       serial_rx_line_i,
    output logic      [7:0] reg_rdata_o,
    output logic            receive_int_flag_o,
    output logic            receiver_idle_flag_o
);

    // ============================================================
    // declarations
    logic            autobaud_enable;
    logic            wake_on_break_enable;
    logic            wide_divisor_select;
    logic            high_speed_select;
    logic            autobaud_overflow_flag;
    logic            receive_int_flag;
    logic            receiver_idle_flag;
    logic     [7:0]  baud_divisor_low;
    logic     [7:0]  baud_divisor_high;
    logic     [7:0]  receive_data_reg;
    logic     [7:0]  reg_rdata;
    logic            rx_prev;
    logic     [8:0]  presc;
    logic     [8:0]  base_mask;
    logic     [8:0]  abd_mask;
    logic            base_tick;
    logic            abd_tick;
    logic            rx_fall;
    logic            rx_rise;
    logic            wake_seen;
    uab_ab_state_t   ab_state;
    uab_ab_state_t   next_ab_state;
    logic     [2:0]  rise_cnt;
    logic            ab_done;
    logic            ab_counting;
    logic     [16:0] next_pair_sum;
    logic            ab_overflow;
    uab_rx_state_t   rx_state;
    logic     [15:0] bit_timer;
    logic     [15:0] bit_period;
    logic     [3:0]  bit_cnt;
    logic     [7:0]  shift_reg;
    logic            rx_enabled;
    logic            rx_byte_done;
    logic            wake_event;
    logic            wr_ctrl;
    logic            rd_data;

    // ============================================================
    // register bus decode
    assign wr_ctrl = reg_write_i && (reg_addr_i == `UAB_ADDR_CTRL);
    assign rd_data = reg_read_i && (reg_addr_i == `UAB_ADDR_RX_DATA);

    // ============================================================
    // line edge detection, runs in sleep too; every user except wake gates the edges with sleep_i
    assign rx_fall = rx_prev && !serial_rx_line_i;
    assign rx_rise = !rx_prev && serial_rx_line_i;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= serial_rx_line_i;
        end
    end

    // ============================================================
    // prescaler: base and autobaud rates from speed bits
    always_comb begin
        case ({wide_divisor_select, high_speed_select})
            2'b00: begin
                base_mask = `UAB_BASE_MASK_SLOW; // [RQ8]
                abd_mask  = `UAB_ABD_MASK_SLOW;
            end
            2'b11: begin
                base_mask = `UAB_BASE_MASK_FAST; // [RQ8]
                abd_mask  = `UAB_ABD_MASK_FAST;
            end
            default: begin
                base_mask = `UAB_BASE_MASK_MID;  // [RQ8]
                abd_mask  = `UAB_ABD_MASK_MID;
            end
        endcase
    end

    // abd mask is base mask widened by three bits: one eighth rate
    assign base_tick = ((presc & base_mask) == base_mask) && !sleep_i;
    assign abd_tick  = ((presc & abd_mask) == abd_mask) && !sleep_i;  // [RQ7]

    // generator stops in sleep
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            presc <= 9'h000;
        end else if (!sleep_i) begin
            presc <= presc + 9'h001; // [RQ17]
        end
    end

    // ============================================================
    // autobaud sequence
    assign ab_counting   = (ab_state == UAB_AB_COUNT);
    assign next_pair_sum = {1'b0, baud_divisor_high, baud_divisor_low} + 17'h00001;
    assign ab_overflow   = ab_counting && abd_tick && next_pair_sum[16] && !ab_done;
    assign ab_done       = ab_counting && rx_rise && (rise_cnt == `UAB_ABD_RISES - 3'h1) && !sleep_i;

    always_comb begin
        next_ab_state = ab_state;
        case (ab_state)
            UAB_AB_OFF: begin
                if (autobaud_enable) begin
                    next_ab_state = wake_on_break_enable ? UAB_AB_BREAK : UAB_AB_START;
                end
            end
            UAB_AB_BREAK: begin
                if (!wake_on_break_enable) begin
                    next_ab_state = UAB_AB_START; // [RQ11]
                end
            end
            UAB_AB_START: begin
                if (rx_fall && !sleep_i) begin
                    next_ab_state = UAB_AB_FIRST;
                end
            end
            UAB_AB_FIRST: begin
                if (rx_rise && !sleep_i) begin
                    next_ab_state = UAB_AB_COUNT; // [RQ3]
                end
            end
            UAB_AB_COUNT: begin
                if (ab_done) begin
                    next_ab_state = UAB_AB_OFF; // [RQ4]
                end
            end
            default: begin
                next_ab_state = UAB_AB_OFF;
            end
        endcase
        if (!autobaud_enable) begin
            next_ab_state = UAB_AB_OFF; // [RQ15]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ab_state <= UAB_AB_OFF;
        end else begin
            ab_state <= next_ab_state;
        end
    end

    // rising edges seen since counting started
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rise_cnt <= 3'h0;
        end else if (ab_state == UAB_AB_FIRST) begin
            rise_cnt <= 3'h1;
        end else if (ab_counting && rx_rise && !sleep_i) begin
            rise_cnt <= rise_cnt + 3'h1; // [RQ2]
        end
    end

    // ============================================================
    // divisor pair: software value or 16-bit calibration counter
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            baud_divisor_low  <= `UAB_RST_DIV;
            baud_divisor_high <= `UAB_RST_DIV;
        end else if (ab_state == UAB_AB_FIRST && rx_rise && !sleep_i) begin
            baud_divisor_low  <= 8'h01; // [RQ9]
            baud_divisor_high <= 8'h00;
        end else if (ab_counting) begin
            if (abd_tick && !ab_done) begin
                baud_divisor_low  <= next_pair_sum[7:0];  // [RQ6]
                baud_divisor_high <= next_pair_sum[15:8]; // [RQ6]
            end
        end else if (reg_write_i && reg_addr_i == `UAB_ADDR_DIV_LOW) begin
            baud_divisor_low <= reg_wdata_i;
        end else if (reg_write_i && reg_addr_i == `UAB_ADDR_DIV_HIGH) begin
            baud_divisor_high <= reg_wdata_i;
        end
    end

    // ============================================================
    // control bits
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wide_divisor_select <= 1'b0;
            high_speed_select   <= 1'b0;
        end else if (wr_ctrl) begin
            wide_divisor_select <= reg_wdata_i[`UAB_BIT_WIDE];
            high_speed_select   <= reg_wdata_i[`UAB_BIT_HSPEED];
        end
    end

    // autobaud enable: software write wins over self clear
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            autobaud_enable <= 1'b0;
        end else if (wr_ctrl) begin
            autobaud_enable <= reg_wdata_i[`UAB_BIT_AB_EN]; // [RQ1]
        end else if (ab_done) begin
            autobaud_enable <= 1'b0; // [RQ4]
        end
    end

    // overflow flag: set wins, cleared only by writing zero
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            autobaud_overflow_flag <= 1'b0;
        end else if (ab_overflow) begin
            autobaud_overflow_flag <= 1'b1; // [RQ12]
        end else if (wr_ctrl && !reg_wdata_i[`UAB_BIT_AB_OVF]) begin
            autobaud_overflow_flag <= 1'b0; // [RQ25]
        end
    end

    // ============================================================
    // wake on break: watches line even in sleep
    assign wake_event = wake_on_break_enable && !wake_seen && rx_fall; // [RQ19] [RQ22]

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wake_on_break_enable <= 1'b0;
            wake_seen            <= 1'b0;
        end else if (wr_ctrl) begin
            wake_on_break_enable <= reg_wdata_i[`UAB_BIT_WAKE_EN];
            wake_seen            <= 1'b0;
        end else if (wake_on_break_enable && wake_seen && rx_rise) begin
            wake_on_break_enable <= 1'b0; // [RQ21]
            wake_seen            <= 1'b0;
        end else if (wake_event) begin
            wake_seen <= 1'b1;
        end
    end

    // ============================================================
    // minimal receiver, blocked by calibration, wake or sleep
    assign rx_enabled   = !autobaud_enable && !wake_on_break_enable && !sleep_i; // [RQ1] [RQ18] [RQ17]
    assign bit_period   = wide_divisor_select ? {baud_divisor_high, baud_divisor_low}
                                              : {8'h00, baud_divisor_low};
    assign rx_byte_done = (rx_state == UAB_RX_STOP) && base_tick && (bit_timer == bit_period);

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rx_state  <= UAB_RX_IDLE;
            bit_timer <= 16'h0000;
            bit_cnt   <= 4'h0;
            shift_reg <= 8'h00;
        end else if (!rx_enabled) begin
            rx_state  <= UAB_RX_IDLE;
            bit_timer <= 16'h0000;
        end else begin
            case (rx_state)
                UAB_RX_IDLE: begin
                    if (rx_fall) begin
                        rx_state  <= UAB_RX_START; // [RQ15]
                        bit_timer <= 16'h0000;
                    end
                end
                UAB_RX_START: begin
                    if (base_tick) begin
                        if (bit_timer == {1'b0, bit_period[15:1]}) begin
                            bit_timer <= 16'h0000;
                            bit_cnt   <= 4'h0;
                            rx_state  <= serial_rx_line_i ? UAB_RX_IDLE : UAB_RX_DATA;
                        end else begin
                            bit_timer <= bit_timer + 16'h0001;
                        end
                    end
                end
                UAB_RX_DATA: begin
                    if (base_tick) begin
                        if (bit_timer == bit_period) begin
                            bit_timer <= 16'h0000;
                            shift_reg <= {serial_rx_line_i, shift_reg[7:1]};
                            bit_cnt   <= bit_cnt + 4'h1;
                            if (bit_cnt == `UAB_DATA_BITS - 4'h1) begin
                                rx_state <= UAB_RX_STOP;
                            end
                        end else begin
                            bit_timer <= bit_timer + 16'h0001;
                        end
                    end
                end
                UAB_RX_STOP: begin
                    if (base_tick) begin
                        if (bit_timer == bit_period) begin
                            bit_timer <= 16'h0000;
                            rx_state  <= UAB_RX_IDLE;
                        end else begin
                            bit_timer <= bit_timer + 16'h0001;
                        end
                    end
                end
                default: begin
                    rx_state <= UAB_RX_IDLE;
                end
            endcase
        end
    end

    // received byte lands in the data register
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            receive_data_reg <= `UAB_RST_DATA;
        end else if (rx_byte_done) begin
            receive_data_reg <= shift_reg;
        end
    end

    // ============================================================
    // receive interrupt flag: any set wins over the read clear
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            receive_int_flag <= 1'b0;
        end else if (ab_done || ab_overflow || wake_event || rx_byte_done) begin
            receive_int_flag <= 1'b1; // [RQ4] [RQ12] [RQ14] [RQ19] [RQ20]
        end else if (rd_data) begin
            receive_int_flag <= 1'b0; // [RQ5]
        end
    end

    // idle flag low while calibration counts or a byte is in flight
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            receiver_idle_flag <= 1'b1;
        end else begin
            receiver_idle_flag <= (ab_done || !ab_counting) && (rx_state == UAB_RX_IDLE); // [RQ13]
        end
    end

    // ============================================================
    // read data, one cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            reg_rdata <= 8'h00;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                `UAB_ADDR_CTRL: begin
                    reg_rdata <= {1'b0, receive_int_flag, receiver_idle_flag,
                                  autobaud_overflow_flag, high_speed_select,
                                  wide_divisor_select, wake_on_break_enable, autobaud_enable};
                end
                `UAB_ADDR_DIV_LOW: begin
                    reg_rdata <= baud_divisor_low;
                end
                `UAB_ADDR_DIV_HIGH: begin
                    reg_rdata <= baud_divisor_high;
                end
                `UAB_ADDR_RX_DATA: begin
                    reg_rdata <= receive_data_reg;
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ============================================================
    // outputs
    assign reg_rdata_o          = reg_rdata;
    assign receive_int_flag_o   = receive_int_flag;
    assign receiver_idle_flag_o = receiver_idle_flag;

endmodule // uab_autobaud_wake

//--- verification/uab_autobaud_wake_chk.sv
`timescale 1ns/1ps
// ============================================================
// port checker for the autobaud and wake block
module uab_autobaud_wake_chk (
    input wire logic       sys_clk_i,
    input wire logic       resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_write_i,
    input wire logic       reg_read_i,
    input wire logic       sleep_i,
    input wire logic       serial_rx_line_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       receive_int_flag_o,
    input wire logic       receiver_idle_flag_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    // ============================================================
    // bus answers
    rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    unmapped_read_a: assert property (reg_read_i && reg_addr_i > 8'h03 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read returned data");
    ctrl_top_a: assert property (reg_read_i && reg_addr_i == 8'h00 |=> reg_rdata_o[7] == 1'b0)
        else $error("control top bit not zero");
    ctrl_status_a: assert property (reg_read_i && reg_addr_i == 8'h00 |=>
        reg_rdata_o[6:5] == {$past(receive_int_flag_o), $past(receiver_idle_flag_o)})
        else $error("status bits differ from flag ports");
    div_readback_a: assert property (reg_write_i && reg_addr_i == 8'h01 && receiver_idle_flag_o ##2
        reg_read_i && reg_addr_i == 8'h01 |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("divisor low readback wrong");

    // ============================================================
    // interrupt flag
    reset_levels_a: assert property (disable iff (1'b0) !resetn_i |=>
        !receive_int_flag_o && receiver_idle_flag_o)
        else $error("flags wrong after reset");
    data_clear_a: assert property (reg_read_i && reg_addr_i == 8'h03 && receiver_idle_flag_o &&
        serial_rx_line_i && $past(serial_rx_line_i) && $past(serial_rx_line_i, 2) |=> !receive_int_flag_o)
        else $error("data read did not clear interrupt");
    int_fall_a: assert property ($fell(receive_int_flag_o) |->
        $past(reg_read_i) && $past(reg_addr_i) == 8'h03)
        else $error("interrupt cleared without data read");
    ctrl_keep_a: assert property (reg_write_i && reg_addr_i == 8'h00 && receive_int_flag_o |=>
        receive_int_flag_o)
        else $error("control write cleared interrupt");

    // ============================================================
    // main scenarios
    int_rise_c: cover property ($rose(receive_int_flag_o));
    busy_c: cover property ($fell(receiver_idle_flag_o));
    sleep_wake_c: cover property (sleep_i && $rose(receive_int_flag_o));
endmodule // uab_autobaud_wake_chk

bind uab_autobaud_wake uab_autobaud_wake_chk u_chk (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .sleep_i(sleep_i),
    .serial_rx_line_i(serial_rx_line_i), .reg_rdata_o(reg_rdata_o),
    .receive_int_flag_o(receive_int_flag_o), .receiver_idle_flag_o(receiver_idle_flag_o));

//--- verification/uab_remote_node.sv
`timescale 1ns/1ps
// ============================================================
// remote serial sender driving the receive line
module uab_remote_node (
    input  wire logic sys_clk_i,
    output logic      line_o
);
    // line idles high between frames
    initial line_o = 1'b1;

    // one frame: start, eight data bits lsb first, stop
    task automatic send_byte(input logic [7:0] b, input int bit_cyc);
        int i;
        @(posedge sys_clk_i);
        line_o <= 1'b0;
        repeat (bit_cyc) @(posedge sys_clk_i);
        for (i = 0; i < 8; i++) begin
            line_o <= b[i];
            repeat (bit_cyc) @(posedge sys_clk_i);
        end
        line_o <= 1'b1;
        repeat (bit_cyc) @(posedge sys_clk_i);
    endtask

    // wake character: all zeros for many bit times, then stop
    task automatic send_break(input int bits, input int bit_cyc);
        @(posedge sys_clk_i);
        line_o <= 1'b0;
        repeat (bits * bit_cyc) @(posedge sys_clk_i);
        line_o <= 1'b1;
        repeat (bit_cyc) @(posedge sys_clk_i);
    endtask
endmodule // uab_remote_node

//--- verification/uab_autobaud_wake_tb.sv
`timescale 1ns/1ps
`include "uab_regs.svh"
// ============================================================
// self-checking bench for the autobaud and wake block
module uab_autobaud_wake_tb;
    logic       sys_clk;
    logic       resetn;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       sleep;
    logic       line;
    logic [7:0] rdata;
    logic       int_flag;
    logic       idle_flag;
    int         mismatches;
    int         compares;
    int         cycles;
    int         p;
    logic [7:0] v;
    logic [7:0] lo;
    logic [7:0] hi;

    uab_autobaud_wake DUT (.sys_clk_i(sys_clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr), .reg_read_i(rd), .sleep_i(sleep), .serial_rx_line_i(line), .reg_rdata_o(rdata),
        .receive_int_flag_o(int_flag), .receiver_idle_flag_o(idle_flag));
    uab_remote_node remote (.sys_clk_i(sys_clk), .line_o(line));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ============================================================
    // compare, report and bus tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_int(input int n);
        int k;
        for (k = 0; k < n && int_flag !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    // timed sync byte; control write skipped when ctrl is zero
    task automatic calib(input logic [7:0] ctrl, input int bit_cyc);
        if (ctrl != 8'h00) wr_reg(`UAB_ADDR_CTRL, ctrl);
        remote.send_byte(8'h55, bit_cyc);
        wait_int(40);
        check(int_flag, 1'b1);
        rd_reg(`UAB_ADDR_CTRL, v);
        check({v[4], v[0]}, 2'b00);
        check(idle_flag, 1'b1);
        rd_reg(`UAB_ADDR_DIV_LOW, lo);
        rd_reg(`UAB_ADDR_DIV_HIGH, hi);
        rd_reg(`UAB_ADDR_RX_DATA, v);
        check(int_flag, 1'b0);
    endtask

    // ============================================================
    // cycle ceiling against hangs
    initial begin
        cycles = 0;
        forever begin
            @(posedge sys_clk);
            cycles++;
            if (cycles == 95000) begin
                mismatches++;
                close_out();
            end
        end
    end

    // ============================================================
    // main sequence
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        sleep = 1'b0;
        resetn = 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        rd_reg(`UAB_ADDR_CTRL, v);
        check(v, 8'h20);
        wr_reg(8'h07, 8'hFF);
        rd_reg(8'h07, v);
        check(v, 8'h00);
        wr_reg(`UAB_ADDR_DIV_LOW, 8'h5A);
        rd_reg(`UAB_ADDR_DIV_LOW, v);
        check(v, 8'h5A);
        // every speed setting, four autobaud ticks per bit
        for (int s = 0; s < 4; s++) begin
            p = (s == 0) ? 512 : (s == 3) ? 32 : 128;
            calib(8'h01 | 8'(s << 2), p * 4);
            check(hi, 8'h00);
            check(lo >= 8'h20 && lo <= 8'h22, 1'b1);
        end
        // count beyond eight bits in narrow divisor mode
        calib(8'h09, 128 * 33);
        check(hi, 8'h01);
        check(lo >= 8'h08 && lo <= 8'h0A, 1'b1);
        // normal reception with software divisor 1Fh; write also drops overflow
        wr_reg(`UAB_ADDR_CTRL, 8'h0C);
        wr_reg(`UAB_ADDR_DIV_LOW, 8'h1F);
        wr_reg(`UAB_ADDR_DIV_HIGH, 8'h00);
        remote.send_byte(8'hA5, 128);
        wait_int(300);
        wr_reg(`UAB_ADDR_CTRL, 8'h0C);
        check(int_flag, 1'b1);
        rd_reg(`UAB_ADDR_RX_DATA, v);
        check(v, 8'hA5);
        // asleep: no character reception
        @(posedge sys_clk);
        sleep <= 1'b1;
        remote.send_byte(8'h3C, 128);
        check(int_flag, 1'b0);
        sleep <= 1'b0;
        // wake on break in sleep, then calibrate following byte
        rd_reg(`UAB_ADDR_CTRL, v);
        check(v[5], 1'b1);
        wr_reg(`UAB_ADDR_CTRL, 8'h0F);
        @(posedge sys_clk);
        sleep <= 1'b1;
        fork
            remote.send_break(13, 128);
            begin
                repeat (20) @(posedge sys_clk);
                #1;
                check(int_flag, 1'b1);
                @(posedge sys_clk);
                sleep <= 1'b0;
                rd_reg(`UAB_ADDR_RX_DATA, v);
                check(int_flag, 1'b0);
                rd_reg(`UAB_ADDR_CTRL, v);
                check(v[1:0], 2'b11);
            end
        join
        repeat (8) @(posedge sys_clk);
        rd_reg(`UAB_ADDR_CTRL, v);
        check(v[1:0], 2'b01);
        check(int_flag, 1'b0);
        calib(8'h00, 128);
        check(lo >= 8'h20 && lo <= 8'h22, 1'b1);
        close_out();
    end
endmodule // uab_autobaud_wake_tb
